// file: uar_receiver.sv
`timescale 1ns/1ps
`include "uar_params.svh"

// Summary of operation
// - Line oversampled at sixteen times the bit rate; shifter advances once per bit.
// - Asynchronous mode only when clocked-mode select is zero and port enable is one.
// - Characters accepted only while continuous receive enable is set.
// - Ninth-bit mode captures ninth bit into status register beside the error flags.
// - Each completed character that passes address detect sets receive flag; interrupt raised when enabled.
// - Reading the receive buffer returns the eight received data bits.
// - Clearing continuous receive enable clears the latched error flags.
// - A priority bit selects the level of the receive interrupt.
// - Address detect off passes all characters; on passes only address characters in ninth-bit mode, all characters otherwise.
// - In sleep the baud generator halts and normal reception stops.
// - Wake-on-edge enable holds receiver idle while watching the line.
// - While armed, a falling line edge is the wake-up event.
// - Wake-up event sets the receive flag, in run and in sleep alike.
// - Reading the receive buffer clears the wake-generated receive flag.
// - First rising edge after wake clears wake enable, then normal reception resumes.
// - Frame is one start, eight or nine data bits, one stop, NRZ.
// - Data bits travel least significant bit first.
// - Baud generator runs at sixteen or sixty-four times bit rate per select bits.
module uar_receiver
  import uar_pkg::*;
#(
  parameter int DIV_WIDTH = 16
)
(
  input  wire logic       clock_in,       // System clock, 10 MHz
  input  wire logic       rst_n_in,       // Asynchronous reset, active low
  input  wire logic       receive_line_in, // Serial receive line
  input  wire logic       sleep_in,       // CPU in sleep, receiver clocks stopped
  input  wire logic [2:0] addr_in,        // Register address
  input  wire logic [7:0] wr_data_in,     // Register write data
  input  wire logic       wr_en_in,       // Write strobe
  input  wire logic       rd_en_in,       // Read strobe
  output logic      [7:0] rd_data_out,    // Read data, cycle after strobe
  output logic            rx_irq_out,     // Receive interrupt request
  output logic            rx_irq_prio_out, // Interrupt level, high when priority set
  output logic            wake_out        // One-cycle wake request pulse
);

  logic                 serial_port_enable;
  logic                 ninth_bit_enable;
  logic                 single_receive_bit;
  logic                 continuous_receive_enable;
  logic                 address_detect_enable;
  logic                 framing_error_flag;
  logic                 overrun_error_flag;
  logic                 received_ninth_bit;
  logic           [7:0] receive_buffer;
  logic           [7:0] transmit_status_control;
  logic                 wide_generator_select;
  logic                 wake_on_edge_enable;
  logic           [7:0] baud_divisor_high;
  logic           [7:0] baud_divisor_low;
  logic                 receive_interrupt_enable;
  logic                 receive_interrupt_priority;
  logic                 receive_complete_flag;
  logic                 wake_seen;
  logic                 line_prev;
  logic [DIV_WIDTH-1:0] brg_count;
  logic           [1:0] prediv;
  logic                 os_tick;
  logic           [3:0] sample_count;
  logic           [3:0] bit_index;
  logic           [8:0] shift_data;
  logic           [2:0] samples;
  uar_state_t           state;

  logic                 async_on;
  logic                 rx_run;
  logic                 high_speed_baud_select;
  logic                 rd_buffer;
  logic                 wr_rcs;
  logic                 line_fall;
  logic                 line_rise;
  logic                 wake_event;
  logic                 bit_value;
  logic                 at_mid;
  logic                 char_done;
  logic                 char_pass;
  logic                 stop_bit;
  logic           [3:0] last_index;
  logic [DIV_WIDTH-1:0] divisor;

  assign high_speed_baud_select = transmit_status_control[`UAR_TXS_HIGH_SPEED_BIT];
  assign async_on = serial_port_enable & ~transmit_status_control[`UAR_TXS_SYNC_BIT];
  // Receiver logic runs only with clocks present and no wake watch armed
  assign rx_run = async_on & ~sleep_in & ~wake_on_edge_enable;
  assign rd_buffer = rd_en_in & (addr_in == `UAR_OFS_RECEIVE_BUFFER);
  assign wr_rcs = wr_en_in & (addr_in == `UAR_OFS_RX_STATUS_CONTROL);
  assign line_fall = line_prev & ~receive_line_in;
  assign line_rise = ~line_prev & receive_line_in;
  assign wake_event = async_on & wake_on_edge_enable & ~wake_seen & line_fall;
  // Majority of three samples around mid-bit tolerates a single glitch
  assign bit_value = (samples[0] & samples[1]) | (samples[1] & samples[2])
                   | (samples[0] & samples[2]);
  assign at_mid = os_tick & (sample_count == `UAR_MID_SAMPLE);
  assign last_index = ninth_bit_enable ? 4'h8 : 4'h7;
  assign stop_bit = bit_value;
  // Receive enable gates completion too, so a clear in the last cycle cannot relatch errors
  assign char_done = rx_run & continuous_receive_enable & (state == UAR_STOP) & at_mid;
  assign char_pass = ~(address_detect_enable & ninth_bit_enable)
                   | shift_data[8];
  assign divisor = wide_generator_select
                 ? DIV_WIDTH'({baud_divisor_high, baud_divisor_low})
                 : DIV_WIDTH'(baud_divisor_low);

  // Baud generator: divisor+1 system clocks per tick, extra /4 in x64 mode
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      brg_count <= '0;
      prediv <= 2'h0;
      os_tick <= 1'b0;
    end
    else if (!async_on || sleep_in)
    begin
      brg_count <= divisor;
      prediv <= 2'h0;
      os_tick <= 1'b0;
    end
    else if (brg_count == '0)
    begin
      brg_count <= divisor;
      if (high_speed_baud_select || wide_generator_select)
      begin
        os_tick <= 1'b1;
      end
      else
      begin
        prediv <= prediv + 2'h1;
        os_tick <= (prediv == `UAR_X64_PREDIV);
      end
    end
    else
    begin
      brg_count <= brg_count - DIV_WIDTH'(1);
      os_tick <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      line_prev <= 1'b1;
    end
    else
    begin
      line_prev <= receive_line_in;
    end
  end

  // Receive state machine, sixteen oversample ticks per bit
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= UAR_IDLE;
      sample_count <= 4'h0;
      bit_index <= 4'h0;
      shift_data <= 9'h000;
      samples <= 3'h7;
    end
    else if (!rx_run || !continuous_receive_enable || overrun_error_flag)
    begin
      state <= UAR_IDLE;
      sample_count <= 4'h0;
      bit_index <= 4'h0;
      samples <= 3'h7;
    end
    else if (os_tick)
    begin
      samples <= {samples[1:0], receive_line_in};
      sample_count <= sample_count + 4'h1;
      unique case (state)
        UAR_IDLE:
        begin
          sample_count <= 4'h0;
          if (!receive_line_in)
          begin
            state <= UAR_START;
            sample_count <= 4'h1;
          end
        end
        UAR_START:
        begin
          if (sample_count == `UAR_MID_SAMPLE)
          begin
            // A start bit that is high again at mid-bit was noise
            state <= bit_value ? UAR_IDLE : UAR_START;
          end
          else if (sample_count == `UAR_LAST_SAMPLE)
          begin
            state <= UAR_DATA;
            bit_index <= 4'h0;
          end
        end
        UAR_DATA:
        begin
          if (sample_count == `UAR_MID_SAMPLE)
          begin
            shift_data[bit_index] <= bit_value;
          end
          else if (sample_count == `UAR_LAST_SAMPLE)
          begin
            bit_index <= bit_index + 4'h1;
            if (bit_index == last_index)
            begin
              state <= UAR_STOP;
            end
          end
        end
        UAR_STOP:
        begin
          // Back to idle at mid-stop so a following start edge is not missed
          if (sample_count == `UAR_MID_SAMPLE)
          begin
            state <= UAR_IDLE;
            shift_data <= 9'h000;
          end
        end
      endcase
    end
  end

  // Receive buffer, ninth bit and error flags
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      receive_buffer <= `UAR_RESET_BYTE;
      received_ninth_bit <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
    end
    else if (wr_rcs && !wr_data_in[`UAR_RCS_CONT_EN_BIT])
    begin
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
    end
    else if (char_done && char_pass)
    begin
      if (receive_complete_flag && !rd_buffer)
      begin
        overrun_error_flag <= 1'b1;
      end
      else
      begin
        receive_buffer <= shift_data[7:0];
        received_ninth_bit <= ninth_bit_enable & shift_data[8];
        framing_error_flag <= ~stop_bit;
      end
    end
  end

  // Receive flag: a new set wins over the clear by a buffer read
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      receive_complete_flag <= 1'b0;
    end
    else if (wake_event)
    begin
      receive_complete_flag <= 1'b1;
    end
    else if (char_done && char_pass && (!receive_complete_flag || rd_buffer))
    begin
      receive_complete_flag <= 1'b1;
    end
    else if (rd_buffer)
    begin
      receive_complete_flag <= 1'b0;
    end
  end

  // Wake-on-edge watch
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wake_on_edge_enable <= 1'b0;
      wake_seen <= 1'b0;
      wake_out <= 1'b0;
    end
    else
    begin
      wake_out <= wake_event & sleep_in;
      if (wake_event)
      begin
        wake_seen <= 1'b1;
      end
      else if (wake_seen && line_rise)
      begin
        wake_on_edge_enable <= 1'b0;
        wake_seen <= 1'b0;
      end
      else if (wr_en_in && addr_in == `UAR_OFS_BAUD_CONTROL)
      begin
        wake_on_edge_enable <= wr_data_in[`UAR_BDC_WAKE_EN_BIT];
        wake_seen <= 1'b0;
      end
    end
  end

  // Software-written control registers
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      serial_port_enable <= 1'b0;
      ninth_bit_enable <= 1'b0;
      single_receive_bit <= 1'b0;
      continuous_receive_enable <= 1'b0;
      address_detect_enable <= 1'b0;
      transmit_status_control <= `UAR_TXS_RESET;
      wide_generator_select <= 1'b0;
      baud_divisor_high <= `UAR_RESET_BYTE;
      baud_divisor_low <= `UAR_RESET_BYTE;
      receive_interrupt_enable <= 1'b0;
      receive_interrupt_priority <= 1'b0;
    end
    else if (wr_en_in)
    begin
      unique case (addr_in)
        `UAR_OFS_RX_STATUS_CONTROL:
        begin
          serial_port_enable <= wr_data_in[`UAR_RCS_PORT_EN_BIT];
          ninth_bit_enable <= wr_data_in[`UAR_RCS_NINTH_EN_BIT];
          single_receive_bit <= wr_data_in[`UAR_RCS_SINGLE_BIT];
          continuous_receive_enable <= wr_data_in[`UAR_RCS_CONT_EN_BIT];
          address_detect_enable <= wr_data_in[`UAR_RCS_ADDR_DET_BIT];
        end
        `UAR_OFS_TX_STATUS_CONTROL:
        begin
          transmit_status_control <= wr_data_in;
        end
        `UAR_OFS_BAUD_CONTROL:
        begin
          wide_generator_select <= wr_data_in[`UAR_BDC_WIDE_BIT];
        end
        `UAR_OFS_BAUD_DIVISOR_HIGH:
        begin
          baud_divisor_high <= wr_data_in;
        end
        `UAR_OFS_BAUD_DIVISOR_LOW:
        begin
          baud_divisor_low <= wr_data_in;
        end
        `UAR_OFS_IRQ_CONTROL:
        begin
          receive_interrupt_enable <= wr_data_in[`UAR_IRC_ENABLE_BIT];
          receive_interrupt_priority <= wr_data_in[`UAR_IRC_PRIO_BIT];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Interrupt request follows the flag while enabled, interrupt level follows the priority bit, one cycle later
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_irq_out <= 1'b0;
      rx_irq_prio_out <= 1'b0;
    end
    else
    begin
      rx_irq_out <= receive_complete_flag & receive_interrupt_enable;
      rx_irq_prio_out <= receive_interrupt_priority;
    end
  end

  // Register reads; data stands in the cycle after the strobe only
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_data_out <= 8'h00;
    end
    else if (!rd_en_in)
    begin
      rd_data_out <= 8'h00;
    end
    else
    begin
      unique case (addr_in)
        `UAR_OFS_RX_STATUS_CONTROL:
        begin
          rd_data_out <= {serial_port_enable, ninth_bit_enable, single_receive_bit,
                          continuous_receive_enable, address_detect_enable,
                          framing_error_flag, overrun_error_flag,
                          received_ninth_bit};
        end
        `UAR_OFS_RECEIVE_BUFFER:
        begin
          rd_data_out <= receive_buffer;
        end
        `UAR_OFS_TX_STATUS_CONTROL:
        begin
          // No transmitter here, so its shift register always reads empty
          rd_data_out <= transmit_status_control | 8'h02;
        end
        `UAR_OFS_BAUD_CONTROL:
        begin
          rd_data_out <= {1'b0, state == UAR_IDLE, 2'b00, wide_generator_select,
                          1'b0, wake_on_edge_enable, 1'b0};
        end
        `UAR_OFS_BAUD_DIVISOR_HIGH:
        begin
          rd_data_out <= baud_divisor_high;
        end
        `UAR_OFS_BAUD_DIVISOR_LOW:
        begin
          rd_data_out <= baud_divisor_low;
        end
        `UAR_OFS_IRQ_CONTROL:
        begin
          rd_data_out <= {6'h00, receive_interrupt_priority, receive_interrupt_enable};
        end
        `UAR_OFS_IRQ_STATUS:
        begin
          rd_data_out <= {7'h00, receive_complete_flag};
        end
        default:
        begin
          rd_data_out <= 8'h00;
        end
      endcase
    end
  end

endmodule

// file: uar_params.svh
`ifndef UAR_PARAMS_SVH
`define UAR_PARAMS_SVH

// Register offsets on the plain register port
`define UAR_OFS_RX_STATUS_CONTROL 3'h0
`define UAR_OFS_RECEIVE_BUFFER    3'h1
`define UAR_OFS_TX_STATUS_CONTROL 3'h2
`define UAR_OFS_BAUD_CONTROL      3'h3
`define UAR_OFS_BAUD_DIVISOR_HIGH 3'h4
`define UAR_OFS_BAUD_DIVISOR_LOW  3'h5
`define UAR_OFS_IRQ_CONTROL       3'h6
`define UAR_OFS_IRQ_STATUS        3'h7

// receive_status_control fields
`define UAR_RCS_PORT_EN_BIT    7
`define UAR_RCS_NINTH_EN_BIT   6
`define UAR_RCS_SINGLE_BIT     5
`define UAR_RCS_CONT_EN_BIT    4
`define UAR_RCS_ADDR_DET_BIT   3
`define UAR_RCS_FRAME_ERR_BIT  2
`define UAR_RCS_OVERRUN_BIT    1
`define UAR_RCS_NINTH_DATA_BIT 0

// transmit_status_control fields
`define UAR_TXS_SYNC_BIT       4
`define UAR_TXS_HIGH_SPEED_BIT 2
`define UAR_TXS_EMPTY_BIT      1

// baud_control fields
`define UAR_BDC_IDLE_BIT    6
`define UAR_BDC_WIDE_BIT    3
`define UAR_BDC_WAKE_EN_BIT 1

// irq_control and irq_status fields
`define UAR_IRC_ENABLE_BIT 0
`define UAR_IRC_PRIO_BIT   1
`define UAR_IRS_FLAG_BIT   0

// Reset values
`define UAR_RESET_BYTE 8'h00
`define UAR_TXS_RESET  8'h02

// Oversampling and sample points
`define UAR_OVERSAMPLE   16
`define UAR_MID_SAMPLE   4'h8
`define UAR_LAST_SAMPLE  4'hF
`define UAR_X64_PREDIV   2'h3

`endif

// file: uar_pkg.sv
package uar_pkg;

  typedef enum logic [1:0]
  {
    UAR_IDLE,
    UAR_START,
    UAR_DATA,
    UAR_STOP
  } uar_state_t;

endpackage

// file: uar_receiver_monitor.sv
`timescale 1ns/1ps
`include "uar_params.svh"
module uar_rx_checker
  import uar_pkg::*;
#(
  parameter int DIV_WIDTH = 16
)
(
  input wire logic       clock_in,        // System clock
  input wire logic       rst_n_in,        // Asynchronous reset, active low
  input wire logic       receive_line_in, // Serial receive line
  input wire logic       sleep_in,        // CPU asleep
  input wire logic [2:0] addr_in,         // Register address
  input wire logic [7:0] wr_data_in,      // Register write data
  input wire logic       wr_en_in,        // Write strobe
  input wire logic       rd_en_in,        // Read strobe
  input wire logic [7:0] rd_data_out,     // Read data
  input wire logic       rx_irq_out,      // Receive interrupt request
  input wire logic       rx_irq_prio_out, // Interrupt level
  input wire logic       wake_out         // Wake pulse
);
  logic ie_shadow;
  logic prio_shadow;

  // Kept from the write strobes alone, so a register that never updates shows up
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ie_shadow   <= 1'b0;
      prio_shadow <= 1'b0;
    end
    else if (wr_en_in && addr_in == `UAR_OFS_IRQ_CONTROL)
    begin
      ie_shadow   <= wr_data_in[`UAR_IRC_ENABLE_BIT];
      prio_shadow <= wr_data_in[`UAR_IRC_PRIO_BIT];
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence continuous_receive_enable_cleared_s;
    wr_en_in && addr_in == `UAR_OFS_RX_STATUS_CONTROL && !wr_data_in[`UAR_RCS_CONT_EN_BIT];
  endsequence

  sequence status_read_s;
    rd_en_in && addr_in == `UAR_OFS_RX_STATUS_CONTROL;
  endsequence

  read_idle_zero_a: assert property (!rd_en_in |=> rd_data_out == 8'h00)
    else $error("read data not zero outside a read");
  irq_needs_enable_a: assert property (rx_irq_out |-> $past(ie_shadow))
    else $error("interrupt raised while disabled");
  irq_mask_drop_a: assert property ((wr_en_in && addr_in == `UAR_OFS_IRQ_CONTROL
    && !wr_data_in[`UAR_IRC_ENABLE_BIT]) |=> ##1 !rx_irq_out)
    else $error("interrupt stays after disable");
  prio_level_a: assert property (rx_irq_prio_out == $past(prio_shadow))
    else $error("priority output does not follow its bit");
  irq_ctrl_read_a: assert property ((rd_en_in && addr_in == `UAR_OFS_IRQ_CONTROL)
    |=> rd_data_out == {6'h00, prio_shadow, ie_shadow})
    else $error("interrupt control reads wrong");
  irq_status_read_a: assert property ((rd_en_in && addr_in == `UAR_OFS_IRQ_STATUS)
    |=> rd_data_out[7:1] == 7'h00)
    else $error("interrupt status unused bits set");
  baud_reserved_a: assert property ((rd_en_in && addr_in == `UAR_OFS_BAUD_CONTROL)
    |=> (rd_data_out & 8'hB5) == 8'h00)
    else $error("baud control unused bits set");
  wake_pulse_a: assert property (wake_out |=> !wake_out)
    else $error("wake pulse longer than one cycle");
  wake_cause_a: assert property (wake_out |-> $past(sleep_in) && !$past(receive_line_in))
    else $error("wake pulse without low line in sleep");
  err_clear_a: assert property (continuous_receive_enable_cleared_s ##2 status_read_s |=> rd_data_out[2:1] == 2'b00)
    else $error("errors remain after receive disable");
endmodule

bind uar_receiver uar_rx_checker #(.DIV_WIDTH(DIV_WIDTH)) u_checker
(
  .clock_in        (clock_in),
  .rst_n_in        (rst_n_in),
  .receive_line_in (receive_line_in),
  .sleep_in        (sleep_in),
  .addr_in         (addr_in),
  .wr_data_in      (wr_data_in),
  .wr_en_in        (wr_en_in),
  .rd_en_in        (rd_en_in),
  .rd_data_out     (rd_data_out),
  .rx_irq_out      (rx_irq_out),
  .rx_irq_prio_out (rx_irq_prio_out),
  .wake_out        (wake_out)
);

// file: uar_line_model.sv
`timescale 1ns/1ps
module uar_line_model
(
  input  wire logic clock_in, // Bit timing reference
  output logic      line_out  // Serial line, idles high
);
  initial line_out = 1'b1;

  task automatic hold_line(input logic level, input int clks);
    @(posedge clock_in);
    line_out <= level;
    repeat (clks - 1) @(posedge clock_in);
  endtask

  task automatic send_char(input logic [8:0] data, input int nbits, input logic good_stop,
                           input int bit_clks);
    hold_line(1'b0, bit_clks);
    for (int i = 0; i < nbits; i++)
      hold_line(data[i], bit_clks);
    if (good_stop)
      hold_line(1'b1, bit_clks);
    else
    begin
      // Low just past mid-stop; the tail is too short to pass a start check
      hold_line(1'b0, bit_clks / 2 + 4);
      hold_line(1'b1, bit_clks);
    end
  endtask
endmodule

// file: tb_async_uart_receiver_wake.sv
`timescale 1ns/1ps
`include "uar_params.svh"
module tb_async_uart_receiver_wake
  import uar_pkg::*;
;
  localparam logic [2:0] RXS = `UAR_OFS_RX_STATUS_CONTROL;
  localparam logic [2:0] BUF = `UAR_OFS_RECEIVE_BUFFER;
  localparam logic [2:0] TXS = `UAR_OFS_TX_STATUS_CONTROL;
  localparam logic [2:0] BDC = `UAR_OFS_BAUD_CONTROL;
  localparam logic [2:0] IRC = `UAR_OFS_IRQ_CONTROL;
  localparam logic [2:0] IRS = `UAR_OFS_IRQ_STATUS;
  logic       clock_in;
  logic       rst_n_in;
  logic       line;
  logic       sleep_in;
  logic [2:0] addr_in;
  logic [7:0] wr_data_in;
  logic       wr_en_in;
  logic       rd_en_in;
  logic [7:0] rd_data_out;
  logic       rx_irq_out;
  logic       rx_irq_prio_out;
  logic       wake_out;
  logic [7:0] wake_seen = 8'h00;
  logic [7:0] rdata;
  int         failures;
  int         comparisons;
  // Per baud mode: tx status, baud control, divisor high, divisor low, clocks per bit, data
  logic [7:0] m_txs [3] = '{8'h04, 8'h00, 8'h00};
  logic [7:0] m_bdc [3] = '{8'h00, 8'h00, 8'h08};
  logic [7:0] m_dvh [3] = '{8'h01, 8'h00, 8'h00};
  logic [7:0] m_dvl [3] = '{8'h01, 8'h00, 8'h01};
  int         m_bit [3] = '{32, 64, 32};
  logic [7:0] m_dat [3] = '{8'h4B, 8'hD2, 8'h1E};
  logic [7:0] g_rxs [3] = '{8'h80, 8'h10, 8'h90};
  logic [7:0] g_txs [3] = '{8'h04, 8'h04, 8'h14};

  uar_receiver #(.DIV_WIDTH(16)) uut
  (
    .clock_in        (clock_in),
    .rst_n_in        (rst_n_in),
    .receive_line_in (line),
    .sleep_in        (sleep_in),
    .addr_in         (addr_in),
    .wr_data_in      (wr_data_in),
    .wr_en_in        (wr_en_in),
    .rd_en_in        (rd_en_in),
    .rd_data_out     (rd_data_out),
    .rx_irq_out      (rx_irq_out),
    .rx_irq_prio_out (rx_irq_prio_out),
    .wake_out        (wake_out)
  );

  uar_line_model line_model (.clock_in(clock_in), .line_out(line));

  initial
  begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  always @(posedge clock_in)
    if (wake_out === 1'b1)
      wake_seen <= wake_seen + 8'h01;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_en_in   <= 1'b1;
    @(posedge clock_in);
    wr_en_in   <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    rd_en_in <= 1'b1;
    @(posedge clock_in);
    rd_en_in <= 1'b0;
    #1;
    d = rd_data_out;
  endtask

  task automatic reg_chk(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] mask);
    logic [7:0] d;
    reg_rd(a, d);
    chk8(d & mask, exp, "register read");
  endtask

  task automatic frame_chk(input logic [8:0] data, input int nbits, input logic good,
                           input int bclk, input logic exp_irq);
    line_model.send_char(data, nbits, good, bclk);
    idle(2);
    chk1(rx_irq_out, exp_irq, "receive interrupt");
  endtask

  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clock_in);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end

  initial
  begin
    failures    = 0;
    comparisons = 0;
    rst_n_in    = 1'b0;
    sleep_in    = 1'b0;
    addr_in     = 3'h0;
    wr_data_in  = 8'h00;
    wr_en_in    = 1'b0;
    rd_en_in    = 1'b0;
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int a = 0; a < 8; a++)
      // Baud control shows the receiver idle bit out of reset
      reg_chk(a[2:0], (a == 2) ? `UAR_TXS_RESET : (a == 3) ? 8'h40 : `UAR_RESET_BYTE, 8'hFF);
    reg_wr(RXS, 8'h07);
    reg_chk(RXS, 8'h00, 8'hFF);
    reg_wr(IRS, 8'hFF);
    reg_chk(IRS, 8'h00, 8'hFF);
    reg_wr(IRC, 8'h03);
    reg_chk(IRC, 8'h03, 8'hFF);
    chk1(rx_irq_prio_out, 1'b1, "priority level");
    $display("test registers finished");
    reg_wr(RXS, 8'h90);
    for (int m = 0; m < 3; m++)
    begin
      reg_wr(TXS, m_txs[m]);
      reg_wr(BDC, m_bdc[m]);
      reg_wr(`UAR_OFS_BAUD_DIVISOR_HIGH, m_dvh[m]);
      reg_wr(`UAR_OFS_BAUD_DIVISOR_LOW, m_dvl[m]);
      frame_chk({1'b0, m_dat[m]}, 8, 1'b1, m_bit[m], 1'b1);
      reg_chk(IRS, 8'h01, 8'hFF);
      reg_chk(BUF, m_dat[m], 8'hFF);
      idle(2);
      chk1(rx_irq_out, 1'b0, "flag cleared by read");
    end
    $display("test baud modes finished");
    reg_wr(TXS, 8'h04);
    reg_wr(BDC, 8'h00);
    reg_wr(RXS, 8'hD0);
    frame_chk(9'h1C3, 9, 1'b1, 32, 1'b1);
    reg_chk(RXS, 8'hD1, 8'hFF);
    reg_chk(BUF, 8'hC3, 8'hFF);
    reg_wr(RXS, 8'hD8);
    frame_chk(9'h055, 9, 1'b1, 32, 1'b0);
    frame_chk(9'h1AA, 9, 1'b1, 32, 1'b1);
    reg_chk(RXS, 8'hD9, 8'hFF);
    reg_chk(BUF, 8'hAA, 8'hFF);
    $display("test ninth bit finished");
    reg_wr(RXS, 8'h90);
    frame_chk(9'h066, 8, 1'b0, 32, 1'b1);
    reg_chk(RXS, 8'h94, 8'hFF);
    reg_wr(IRC, 8'h02);
    idle(2);
    chk1(rx_irq_out, 1'b0, "interrupt masked");
    reg_wr(IRC, 8'h03);
    frame_chk(9'h077, 8, 1'b1, 32, 1'b1);
    reg_chk(RXS, 8'h02, 8'h02);
    reg_chk(BUF, 8'h66, 8'hFF);
    reg_wr(RXS, 8'h80);
    reg_chk(RXS, 8'h80, 8'hFF);
    $display("test errors finished");
    for (int g = 0; g < 3; g++)
    begin
      reg_wr(TXS, g_txs[g]);
      reg_wr(RXS, g_rxs[g]);
      frame_chk(9'h0F0, 8, 1'b1, 32, 1'b0);
    end
    reg_wr(TXS, 8'h04);
    $display("test gating finished");
    @(posedge clock_in);
    sleep_in <= 1'b1;
    frame_chk(9'h0A5, 8, 1'b1, 32, 1'b0);
    reg_wr(BDC, 8'h02);
    line_model.hold_line(1'b0, 9 * 32);
    idle(2);
    chk1(rx_irq_out, 1'b1, "wake flag in sleep");
    reg_chk(BDC, 8'h02, 8'h02);
    line_model.hold_line(1'b1, 4 * 32);
    reg_chk(BDC, 8'h00, 8'h02);
    chk8(wake_seen, 8'h01, "wake pulses");
    reg_rd(BUF, rdata);
    idle(2);
    chk1(rx_irq_out, 1'b0, "wake flag cleared");
    @(posedge clock_in);
    sleep_in <= 1'b0;
    reg_wr(BDC, 8'h02);
    // Wake character must be all zero, or its first rising bit ends the wake early
    frame_chk(9'h000, 8, 1'b1, 32, 1'b1);
    line_model.hold_line(1'b1, 4 * 32);
    chk8(wake_seen, 8'h01, "no wake pulse when running");
    reg_rd(BUF, rdata);
    frame_chk(9'h05A, 8, 1'b1, 32, 1'b1);
    reg_chk(BUF, 8'h5A, 8'hFF);
    $display("test wake finished");
    summarize();
  end
endmodule
